// ### inc/sfrdb_pkg.sv
// package: constants for the special-function register decode bank
package sfrdb_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int SFR_IDX_W = 5;
    localparam int SFR_MOD_W = 5;
    localparam int SFR_DATA_W = 16;
    localparam int SFR_NUM_REGS = 64;
    localparam int SFR_SLOT_W = 6;

    // ****************************************
    // module specifiers
    // ****************************************
    localparam logic [4:0] MOD_ZERO = 5'h00;
    localparam logic [4:0] MOD_ONE = 5'h01;
    localparam logic [4:0] MOD_DP = 5'h0F;
    localparam logic [4:0] IDX_DP_ZERO = 5'h03;

    // ****************************************
    // module 0 indices
    // ****************************************
    localparam logic [4:0] IDX_PORT_ZERO_OUTPUT = 5'h00;
    localparam logic [4:0] IDX_TIMER_COUNT = 5'h06;
    localparam logic [4:0] IDX_PORT_ZERO_INPUT = 5'h08;
    localparam logic [4:0] IDX_PORT_ZERO_DIRECTION = 5'h09;
    localparam logic [4:0] IDX_TIMER_WORD_TWO = 5'h0C;
    localparam logic [4:0] IDX_BREAKPOINT = 5'h0F;
    localparam logic [4:0] IDX_LOCK = 5'h17;
    localparam logic [4:0] IDX_DEBUG_FIRST = 5'h18;
    localparam logic [4:0] IDX_DEBUG_TEMP_ONE = 5'h19;
    localparam logic [4:0] IDX_DEBUG_ADDRESS = 5'h1D;
    localparam logic [4:0] IDX_DEBUG_LAST = 5'h1E;

    // ****************************************
    // module 1 indices
    // ****************************************
    localparam logic [4:0] IDX_FE_FIRST = 5'h00;
    localparam logic [4:0] IDX_FE_POWERDOWN = 5'h03;
    localparam logic [4:0] IDX_FE_LAST = 5'h07;
    localparam logic [4:0] IDX_RESULT_FIRST = 5'h08;
    localparam logic [4:0] IDX_THRESH_LAST = 5'h0F;
    localparam logic [4:0] IDX_OFFSET_FIRST = 5'h10;
    localparam logic [4:0] IDX_FE_INT_ENABLE = 5'h14;

    // ****************************************
    // slot numbers inside the flat bank (slot = module*32 + index)
    // ****************************************
    localparam logic [5:0] SLOT_PORT_ZERO_OUTPUT = 6'h00;
    localparam logic [5:0] SLOT_SCAN_TIMING = 6'h21;
    localparam logic [5:0] SLOT_CAP_RANGE = 6'h22;
    localparam logic [5:0] SLOT_WAKEUP_CH1 = 6'h24;
    localparam logic [5:0] SLOT_WAKEUP_CH2 = 6'h25;
    localparam logic [5:0] SLOT_EXC_LOW = 6'h26;

    // ****************************************
    // reset values; unused bits are zero
    // ****************************************
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_PORT_ZERO_OUTPUT = 16'h007F;
    localparam logic [15:0] RST_SCAN_TIMING = 16'h0002;
    localparam logic [15:0] RST_CAP_RANGE = 16'h0022;
    localparam logic [15:0] RST_WAKEUP = 16'h0004;
    localparam logic [15:0] RST_EXC_LOW = 16'h001E;
    localparam logic [15:0] MASK_BYTE = 16'h00FF;
    localparam logic [15:0] MASK_WORD = 16'hFFFF;
    localparam logic [15:0] MASK_NONE = 16'h0000;
    localparam logic [15:0] DP_STEP = 16'h0001;

    typedef enum logic [1:0] {
        SFRDB_DP_HOLD,
        SFRDB_DP_INC,
        SFRDB_DP_DEC
    } sfrdb_dp_step_type;
endpackage : sfrdb_pkg

// ### design/sfrdb_decode.sv
// combinational decoder from module/index pair to bank slot and width
`timescale 1ns/1ps
module sfrdb_decode
    import sfrdb_pkg::*;
(
    input wire logic [SFR_MOD_W-1:0] mod_i, // module specifier
    input wire logic [SFR_IDX_W-1:0] idx_i, // register index
    output logic [SFR_SLOT_W-1:0] slot_o, // bank slot
    output logic [SFR_DATA_W-1:0] mask_o // implemented bits, zero when reserved
);
    // ****************************************
    // width of each location
    // ****************************************
    function automatic logic [15:0] sfrdb_width(input logic [4:0] m, input logic [4:0] i);
        logic [15:0] w;
        w = MASK_NONE;
        if (m == MOD_ZERO) begin
            if (i <= IDX_TIMER_COUNT) begin
                w = MASK_BYTE;
            end else if (i == IDX_PORT_ZERO_INPUT || i == IDX_PORT_ZERO_DIRECTION) begin
                w = MASK_BYTE;
            end else if (i == IDX_TIMER_WORD_TWO || i == IDX_BREAKPOINT) begin
                w = MASK_WORD;
            end else if (i == IDX_LOCK) begin
                w = MASK_BYTE;
            end else if (i == IDX_DEBUG_FIRST || i == IDX_DEBUG_TEMP_ONE
                         || i >= IDX_DEBUG_ADDRESS && i <= IDX_DEBUG_LAST) begin
                w = MASK_WORD;
            end else if (i > IDX_DEBUG_TEMP_ONE && i < IDX_DEBUG_ADDRESS) begin
                w = MASK_BYTE;
            end
        end else if (m == MOD_ONE) begin
            if (i <= IDX_THRESH_LAST) begin
                w = MASK_BYTE;
            end else if (i >= IDX_OFFSET_FIRST && i <= IDX_FE_INT_ENABLE) begin
                w = MASK_BYTE;
            end
        end
        return w;
    endfunction : sfrdb_width

    always_comb begin
        mask_o = sfrdb_width(mod_i, idx_i);
        slot_o = {mod_i[0], idx_i};
    end
endmodule : sfrdb_decode

// ### design/sfrdb_data_pointer.sv
// sixteen-bit data pointer zero with automatic step
`timescale 1ns/1ps
module sfrdb_data_pointer
    import sfrdb_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic reset_i, // synchronous reset, any source
    input wire logic wr_i, // software write
    input wire logic [SFR_DATA_W-1:0] wdata_i, // write data
    input wire sfrdb_dp_step_type step_i, // step with a data-memory access
    output logic [SFR_DATA_W-1:0] value_o // pointer value
);
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            value_o <= RST_ZERO;
        end else if (wr_i) begin
            value_o <= wdata_i;
        end else begin
            case (step_i)
                SFRDB_DP_INC: value_o <= value_o + DP_STEP;
                SFRDB_DP_DEC: value_o <= value_o - DP_STEP;
                default: value_o <= value_o;
            endcase
        end
    end

    AST_DP_RESET_ZERO: assert property (@(posedge clk_sys_i)
        reset_i |=> value_o == RST_ZERO)
        else $error("data pointer not cleared by reset");
    AST_DP_STEP_UP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !wr_i && step_i == SFRDB_DP_INC |=> value_o == $past(value_o) + DP_STEP)
        else $error("data pointer did not increment");
endmodule : sfrdb_data_pointer

// ### design/sfrdb_bank.sv
// special-function register decoder and register bank with data pointer zero
`timescale 1ns/1ps
module sfrdb_bank
    import sfrdb_pkg::*;
#(
    parameter int NUM_REGS = SFR_NUM_REGS
) (
    input wire logic clk_sys_i, // system clock, 40 MHz
    input wire logic reset_i, // synchronous reset, active high
    input wire logic [SFR_MOD_W-1:0] sfr_mod_i, // module specifier
    input wire logic [SFR_IDX_W-1:0] sfr_idx_i, // register index
    input wire logic sfr_wr_i, // write strobe
    input wire logic sfr_rd_i, // read strobe
    input wire logic [SFR_DATA_W-1:0] sfr_wdata_i, // write data
    input wire sfrdb_dp_step_type dp_step_i, // pointer step from data-memory access
    output logic [SFR_DATA_W-1:0] sfr_rdata_o, // registered read data
    output logic sfr_rvalid_o, // read data valid, one cycle
    output logic [SFR_DATA_W-1:0] data_pointer_zero_o, // data pointer zero
    output logic [SFR_DATA_W-1:0] port_zero_output_o, // port 0 output register
    output logic [SFR_DATA_W-1:0] port_zero_direction_o, // port 0 direction register
    output logic [SFR_DATA_W-1:0] frontend_powerdown_o // front-end power-down register
);
    // ****************************************
    // decode
    // ****************************************
    logic [SFR_SLOT_W-1:0] slot;
    logic [SFR_DATA_W-1:0] mask;
    logic is_dp;
    logic dp_wr;
    logic [SFR_DATA_W-1:0] dp_value;
    logic [SFR_DATA_W-1:0] bank [NUM_REGS];
    logic [SFR_DATA_W-1:0] next_rdata;

    sfrdb_decode u_decode (
        .mod_i(sfr_mod_i),
        .idx_i(sfr_idx_i),
        .slot_o(slot),
        .mask_o(mask)
    );

    always_comb begin
        is_dp = (sfr_mod_i == MOD_DP) && (sfr_idx_i == IDX_DP_ZERO);
        dp_wr = sfr_wr_i && is_dp;
    end

    // ****************************************
    // data pointer zero
    // ****************************************
    sfrdb_data_pointer u_dp (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .wr_i(dp_wr),
        .wdata_i(sfr_wdata_i),
        .step_i(dp_step_i),
        .value_o(dp_value)
    );

    // ****************************************
    // register bank
    // ****************************************
    function automatic logic [15:0] sfrdb_reset_value(input int s);
        logic [15:0] v;
        v = RST_ZERO;
        if (s == int'(SLOT_PORT_ZERO_OUTPUT)) begin
            v = RST_PORT_ZERO_OUTPUT;
        end else if (s == int'(SLOT_SCAN_TIMING)) begin
            v = RST_SCAN_TIMING;
        end else if (s == int'(SLOT_CAP_RANGE)) begin
            v = RST_CAP_RANGE;
        end else if (s == int'(SLOT_WAKEUP_CH1) || s == int'(SLOT_WAKEUP_CH2)) begin
            v = RST_WAKEUP;
        end else if (s == int'(SLOT_EXC_LOW)) begin
            v = RST_EXC_LOW;
        end
        return v;
    endfunction : sfrdb_reset_value

    // peripheral behaviour lives elsewhere; this bank only stores what software writes
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    bank[g] <= sfrdb_reset_value(g);
                end else if (sfr_wr_i && !is_dp && slot == SFR_SLOT_W'(g)
                             && mask != MASK_NONE) begin
                    bank[g] <= sfr_wdata_i & mask;
                end
            end
        end
    endgenerate

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        if (is_dp) begin
            next_rdata = dp_value;
        end else begin
            next_rdata = bank[slot] & mask;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sfr_rdata_o <= RST_ZERO;
            sfr_rvalid_o <= 1'b0;
        end else begin
            sfr_rdata_o <= sfr_rd_i ? next_rdata : RST_ZERO;
            sfr_rvalid_o <= sfr_rd_i;
        end
    end

    // ****************************************
    // register outputs
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            data_pointer_zero_o <= RST_ZERO;
            port_zero_output_o <= RST_PORT_ZERO_OUTPUT;
            port_zero_direction_o <= RST_ZERO;
            frontend_powerdown_o <= RST_ZERO;
        end else begin
            // one cycle behind the internal registers, kept for flop-driven outputs
            data_pointer_zero_o <= dp_value;
            port_zero_output_o <= bank[SLOT_PORT_ZERO_OUTPUT];
            port_zero_direction_o <= bank[{1'b0, IDX_PORT_ZERO_DIRECTION}];
            frontend_powerdown_o <= bank[{1'b1, IDX_FE_POWERDOWN}];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_RESERVED_READ_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_rd_i && !is_dp && mask == MASK_NONE |=> sfr_rdata_o == RST_ZERO && sfr_rvalid_o)
        else $error("reserved location did not read zero");
    AST_MOD2_RESERVED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i > MOD_ONE && sfr_mod_i != MOD_DP |-> mask == MASK_NONE)
        else $error("module above one decoded as a register");
    AST_BYTE_WIDTH: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_rd_i && mask == MASK_BYTE |=> sfr_rdata_o[15:8] == 8'h00)
        else $error("byte register returned upper bits");
    AST_WRITE_READBACK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_wr_i && mask == MASK_WORD ##1 sfr_rd_i && !sfr_wr_i
        && $stable(sfr_mod_i) && $stable(sfr_idx_i)
        && dp_step_i == SFRDB_DP_HOLD
        |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
        else $error("word register did not read back");
    AST_DP_READ: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_rd_i && is_dp |=> sfr_rdata_o == $past(dp_value))
        else $error("data pointer read wrong");
    AST_UNASSIGNED_M0: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i == IDX_TIMER_COUNT + 5'h01 |-> mask == MASK_NONE)
        else $error("module zero index seven not reserved");
    AST_PORT_RESET: assert property (@(posedge clk_sys_i)
        reset_i ##1 reset_i |=> port_zero_output_o == RST_PORT_ZERO_OUTPUT)
        else $error("port zero output reset value wrong");
    AST_M1_OFFSET: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ONE && sfr_idx_i == IDX_FE_INT_ENABLE + 5'h01 |-> mask == MASK_NONE)
        else $error("module one index past enable not reserved");

    // ****************************************
    // decode map checks
    // ****************************************
    AST_M0_LOW_BYTE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i <= IDX_TIMER_COUNT
        |-> mask == MASK_BYTE)
        else $error("module zero low block not byte wide");

    AST_M1_LOW_BYTE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ONE && sfr_idx_i <= IDX_FE_LAST
        |-> mask == MASK_BYTE)
        else $error("module one low block not byte wide");

    AST_M0_PORT_BYTE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO
        && (sfr_idx_i == IDX_PORT_ZERO_INPUT || sfr_idx_i == IDX_PORT_ZERO_DIRECTION)
        |-> mask == MASK_BYTE)
        else $error("port input or direction not byte wide");

    AST_M0_MID_WORD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO
        && (sfr_idx_i == IDX_TIMER_WORD_TWO || sfr_idx_i == IDX_BREAKPOINT)
        |-> mask == MASK_WORD)
        else $error("timer word or breakpoint not word wide");

    AST_M0_MID_GAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i > IDX_PORT_ZERO_DIRECTION
        && sfr_idx_i < IDX_BREAKPOINT && sfr_idx_i != IDX_TIMER_WORD_TWO
        |-> mask == MASK_NONE)
        else $error("module zero middle gap decoded");

    AST_M1_RESULT_BYTE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ONE && sfr_idx_i >= IDX_RESULT_FIRST && sfr_idx_i <= IDX_THRESH_LAST
        |-> mask == MASK_BYTE)
        else $error("result or threshold not byte wide");

    AST_M0_HIGH_GAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i > IDX_BREAKPOINT && sfr_idx_i < IDX_LOCK
        |-> mask == MASK_NONE)
        else $error("module zero gap below lock decoded");

    AST_M0_LOCK_BYTE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i == IDX_LOCK
        |-> mask == MASK_BYTE)
        else $error("lock not byte wide");

    AST_M0_TEMP_WORD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO
        && (sfr_idx_i == IDX_DEBUG_FIRST || sfr_idx_i == IDX_DEBUG_TEMP_ONE)
        |-> mask == MASK_WORD)
        else $error("debug temporaries not word wide");

    AST_M0_DEBUG_BYTE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i > IDX_DEBUG_TEMP_ONE
        && sfr_idx_i < IDX_DEBUG_ADDRESS
        |-> mask == MASK_BYTE)
        else $error("debug control flags or buffer not byte wide");

    AST_M0_DEBUG_WORD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i >= IDX_DEBUG_ADDRESS
        && sfr_idx_i <= IDX_DEBUG_LAST
        |-> mask == MASK_WORD)
        else $error("debug address or data not word wide");

    AST_M0_TOP_GAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ZERO && sfr_idx_i > IDX_DEBUG_LAST
        |-> mask == MASK_NONE)
        else $error("module zero last index decoded");

    AST_M1_OFFSET_BYTE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ONE && sfr_idx_i >= IDX_OFFSET_FIRST
        && sfr_idx_i <= IDX_FE_INT_ENABLE
        |-> mask == MASK_BYTE)
        else $error("offset spread or enable not byte wide");

    AST_M1_TOP_GAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i == MOD_ONE && sfr_idx_i > IDX_FE_INT_ENABLE
        |-> mask == MASK_NONE)
        else $error("module one top gap decoded");

    AST_SLOT_MAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_mod_i <= MOD_ONE
        |-> slot[SFR_IDX_W-1:0] == sfr_idx_i && slot[SFR_IDX_W] == (sfr_mod_i == MOD_ONE))
        else $error("slot does not follow module and index");

    AST_MASK_LEGAL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        mask == MASK_NONE || mask == MASK_BYTE || mask == MASK_WORD)
        else $error("location neither byte nor word wide");

    // ****************************************
    // data path checks
    // ****************************************
    AST_RVALID_PULSE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_rd_i
        |=> sfr_rvalid_o)
        else $error("read not answered");

    AST_IDLE_READ_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !sfr_rd_i
        |=> !sfr_rvalid_o && sfr_rdata_o == RST_ZERO)
        else $error("read data shown without a read");

    AST_RESERVED_WRITE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_wr_i && mask == MASK_NONE && slot == SLOT_PORT_ZERO_OUTPUT
        |=> $stable(bank[SLOT_PORT_ZERO_OUTPUT]))
        else $error("reserved write reached port zero output");

    AST_BYTE_WRITE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_wr_i && mask == MASK_BYTE && slot == SLOT_SCAN_TIMING
        |=> bank[SLOT_SCAN_TIMING] == ($past(sfr_wdata_i) & MASK_BYTE))
        else $error("byte write kept upper bits");

    AST_WORD_WRITE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sfr_wr_i && mask == MASK_WORD && slot == {1'b0, IDX_BREAKPOINT}
        |=> bank[{1'b0, IDX_BREAKPOINT}] == $past(sfr_wdata_i))
        else $error("word write lost bits");

    AST_DP_WRITE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        dp_wr
        |=> dp_value == $past(sfr_wdata_i))
        else $error("data pointer write lost");

    AST_DP_STEP_DOWN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !dp_wr && dp_step_i == SFRDB_DP_DEC
        |=> dp_value == $past(dp_value) - DP_STEP)
        else $error("data pointer did not decrement");

    AST_DP_COPY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !reset_i
        |=> data_pointer_zero_o == $past(dp_value))
        else $error("data pointer output does not follow");

    AST_DIR_COPY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !reset_i
        |=> port_zero_direction_o == $past(bank[{1'b0, IDX_PORT_ZERO_DIRECTION}]))
        else $error("direction output does not follow");

    AST_RESET_SCAN: assert property (@(posedge clk_sys_i)
        reset_i
        |=> bank[SLOT_SCAN_TIMING] == RST_SCAN_TIMING)
        else $error("scan timing reset value wrong");

    AST_RESET_RANGE: assert property (@(posedge clk_sys_i)
        reset_i
        |=> bank[SLOT_CAP_RANGE] == RST_CAP_RANGE)
        else $error("range reset value wrong");

    AST_RESET_READ: assert property (@(posedge clk_sys_i)
        reset_i
        |=> !sfr_rvalid_o && sfr_rdata_o == RST_ZERO)
        else $error("read port not idle after reset");
endmodule : sfrdb_bank

// ### tb/sfrdb_cpu_model.sv
// core-side model that issues register reads and writes to the bank
`timescale 1ns/1ps
module sfrdb_cpu_model
    import sfrdb_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic [SFR_DATA_W-1:0] rdata_i, // read data from the bank
    input wire logic rvalid_i, // read data valid
    output logic [SFR_MOD_W-1:0] mod_o, // module specifier
    output logic [SFR_IDX_W-1:0] idx_o, // register index
    output logic wr_o, // write strobe
    output logic rd_o, // read strobe
    output logic [SFR_DATA_W-1:0] wdata_o // write data
);
    initial begin
        mod_o = 5'h00;
        idx_o = 5'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
    end
    // released lines flip so a stale address or data word never looks live
    task automatic release_bus();
        wr_o = 1'b0;
        rd_o = 1'b0;
        mod_o = ~mod_o;
        idx_o = ~idx_o;
        wdata_o = ~wdata_o;
    endtask : release_bus
    // reserved places are only touched when the bench asks for it
    task automatic write(input logic [4:0] m, input logic [4:0] x, input logic [15:0] d);
        @(negedge clk_sys_i);
        mod_o = m;
        idx_o = x;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        release_bus();
    endtask : write
    // write then read the same place on the next edge, no idle cycle between
    task automatic write_read(input logic [4:0] m, input logic [4:0] x, input logic [15:0] wv,
                              output logic [15:0] d, output logic v);
        @(negedge clk_sys_i);
        mod_o = m;
        idx_o = x;
        wdata_o = wv;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        d = rdata_i;
        v = rvalid_i;
        release_bus();
    endtask : write_read
    task automatic read(input logic [4:0] m, input logic [4:0] x, output logic [15:0] d,
                        output logic v);
        @(negedge clk_sys_i);
        mod_o = m;
        idx_o = x;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        d = rdata_i;
        v = rvalid_i;
        release_bus();
    endtask : read
endmodule : sfrdb_cpu_model

// ### tb/sfr_address_decode_bank_test.sv
// self-checking bench for the register decode bank
`timescale 1ns/1ps
module sfr_address_decode_bank_test
    import sfrdb_pkg::*;
;
    typedef struct packed {
        logic [4:0] m;
        logic [4:0] x;
        logic [15:0] r;
        logic [1:0] w;
    } sfrdb_row_type;
    // w: 0 reserved, 1 byte, 2 word
    localparam sfrdb_row_type ROWS [25] = '{
        '{5'h00, 5'h00, 16'h007F, 2'h1}, '{5'h00, 5'h06, 16'h0000, 2'h1},
        '{5'h00, 5'h07, 16'h0000, 2'h0}, '{5'h00, 5'h09, 16'h0000, 2'h1},
        '{5'h00, 5'h0C, 16'h0000, 2'h2}, '{5'h00, 5'h0D, 16'h0000, 2'h0},
        '{5'h00, 5'h0F, 16'h0000, 2'h2}, '{5'h00, 5'h10, 16'h0000, 2'h0},
        '{5'h00, 5'h17, 16'h0000, 2'h1}, '{5'h00, 5'h18, 16'h0000, 2'h2},
        '{5'h00, 5'h1B, 16'h0000, 2'h1}, '{5'h00, 5'h1E, 16'h0000, 2'h2},
        '{5'h00, 5'h1F, 16'h0000, 2'h0}, '{5'h01, 5'h01, 16'h0002, 2'h1},
        '{5'h01, 5'h02, 16'h0022, 2'h1}, '{5'h01, 5'h05, 16'h0004, 2'h1},
        '{5'h01, 5'h06, 16'h001E, 2'h1}, '{5'h01, 5'h07, 16'h0000, 2'h1},
        '{5'h01, 5'h0B, 16'h0000, 2'h1}, '{5'h01, 5'h0F, 16'h0000, 2'h1},
        '{5'h01, 5'h14, 16'h0000, 2'h1}, '{5'h01, 5'h15, 16'h0000, 2'h0},
        '{5'h02, 5'h00, 16'h0000, 2'h0}, '{5'h05, 5'h1F, 16'h0000, 2'h0},
        '{5'h0F, 5'h03, 16'h0000, 2'h2}};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    sfrdb_dp_step_type dp_step = SFRDB_DP_HOLD;
    logic [4:0] mod, idx;
    logic wr, rd, rvalid;
    logic [15:0] wdata, rdata, dp0, pout, pdir, ppd;
    logic [15:0] got;
    logic got_v;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    sfrdb_bank dut (.clk_sys_i(clk_sys), .reset_i(reset), .sfr_mod_i(mod), .sfr_idx_i(idx),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .dp_step_i(dp_step),
        .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid), .data_pointer_zero_o(dp0),
        .port_zero_output_o(pout), .port_zero_direction_o(pdir), .frontend_powerdown_o(ppd));
    sfrdb_cpu_model cpu (.clk_sys_i(clk_sys), .rdata_i(rdata), .rvalid_i(rvalid), .mod_o(mod),
        .idx_o(idx), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rd_chk(input string name, input logic [4:0] m, input logic [4:0] x,
                          input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        cpu.read(m, x, d, v);
        check({name, " valid"}, {15'h0000, v}, 16'h0001);
        check(name, d, exp);
    endtask : rd_chk
    function automatic logic [15:0] wd(input int i);
        return 16'hA5C3 + 16'(i) * 16'h0101;
    endfunction : wd
    function automatic logic [15:0] kept(input int i);
        return (ROWS[i].w == 2'h2) ? wd(i)
            : ((ROWS[i].w == 2'h1) ? (wd(i) & 16'h00FF) : 16'h0000);
    endfunction : kept

    // hang guard well above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        check("pointer at reset", dp0, 16'h0000);
        for (int i = 0; i < 25; i++) begin
            rd_chk("reset value", ROWS[i].m, ROWS[i].x, ROWS[i].r);
            cpu.write(ROWS[i].m, ROWS[i].x, wd(i));
            rd_chk("wrote", ROWS[i].m, ROWS[i].x, kept(i));
        end
        for (int i = 0; i < 25; i++) begin
            rd_chk("retained", ROWS[i].m, ROWS[i].x, kept(i));
        end
        $display("test map done");
        cpu.write(5'h0F, 5'h03, 16'hFFFE);
        dp_step = SFRDB_DP_INC;
        repeat (3) @(negedge clk_sys);
        dp_step = SFRDB_DP_HOLD;
        rd_chk("pointer up", 5'h0F, 5'h03, 16'h0001);
        check("pointer copy", dp0, 16'h0001);
        dp_step = SFRDB_DP_DEC;
        repeat (2) @(negedge clk_sys);
        dp_step = SFRDB_DP_HOLD;
        rd_chk("pointer down", 5'h0F, 5'h03, 16'hFFFF);
        dp_step = SFRDB_DP_INC;
        cpu.write(5'h0F, 5'h03, 16'h1234);
        dp_step = SFRDB_DP_HOLD;
        rd_chk("write beats step", 5'h0F, 5'h03, 16'h1234);
        @(negedge clk_sys);
        check("rvalid drops", {15'h0000, rvalid}, 16'h0000);
        check("rdata drops", rdata, 16'h0000);
        $display("test pointer done");
        cpu.write(5'h00, 5'h09, 16'hBEEF);
        cpu.write(5'h01, 5'h03, 16'h0107);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check("direction copy", pdir, 16'h00EF);
        check("powerdown copy", ppd, 16'h0007);
        $display("test copies done");
        cpu.write_read(5'h00, 5'h1E, 16'h5AA5, got, got_v);
        check("back to back valid", {15'h0000, got_v}, 16'h0001);
        check("back to back data", got, 16'h5AA5);
        $display("test back to back done");
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        check("pointer after reset", dp0, 16'h0000);
        check("port out after reset", pout, 16'h007F);
        check("direction after reset", pdir, 16'h0000);
        rd_chk("pointer reread", 5'h0F, 5'h03, 16'h0000);
        rd_chk("range after reset", 5'h01, 5'h02, 16'h0022);
        $display("test reset done");
        test_done();
    end
endmodule : sfr_address_decode_bank_test
